// [core_status_regs.svh]
// Status codes, field values and reset values of the core status block.
`ifndef CORE_STATUS_REGS_SVH
`define CORE_STATUS_REGS_SVH

`define BRSTAT_IDLE 2'h0
`define BRSTAT_NOT_TAKEN 2'h2
`define BRSTAT_TAKEN 2'h3
`define BRSTAT_VALID_BIT 1

`define PSTAT_STALL 7'h00
`define PSTAT_EXCEPT 7'h04
`define PSTAT_SQUASH 7'h08
`define PSTAT_HALTED 7'h20
`define PSTAT_STOPPED 7'h24
`define PSTAT_CHKSTOP 7'h28
`define PSTAT_GENERIC_BASE 5'h10
`define PSTAT_LSM_STD 7'h44
`define PSTAT_LSM_VAR 7'h4b
`define PSTAT_SHORT_RFI 7'h7c

`define SIZE_32BIT 1'h0
`define SIZE_16BIT 1'h1
`define PAGE_STANDARD 1'h0
`define PAGE_VARIABLE 1'h1

`define SYNDROME_RESET 8'h00
`define SYNDROME_WIDTH 8

`endif

// [core_status_pkg.sv]
// Types shared by the core status block.
package core_status_pkg;

	typedef enum logic [3:0]
	{
		ST_RUN = 4'h1,
		ST_HALTED = 4'h2,
		ST_STOPPED = 4'h4,
		ST_CHKSTOP = 4'h8
	} run_state_t;

	typedef enum logic [2:0]
	{
		CMP_GENERIC = 3'h0,
		CMP_LSM = 3'h1,
		CMP_SHORT_RFI = 3'h2,
		CMP_SPECIAL = 3'h3
	} cmp_class_t;

endpackage

// [sync2.sv]
// Two-flop synchroniser for levels arriving from outside the clock domain.
`timescale 1ns/100ps
module sync2
#(
	parameter int WIDTH = 1
)
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			meta_q <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

// [pstat_encoder.sv]
// Combinational encoder of the processor status code.
`timescale 1ns/100ps
`include "core_status_regs.svh"
module pstat_encoder
(
	input wire core_status_pkg::run_state_t state,
	input wire logic exception,
	input wire logic squash,
	input wire logic cmp_valid,
	input wire core_status_pkg::cmp_class_t cmp_class,
	input wire logic cmp_size16,
	input wire logic cmp_vle,
	input wire logic [6:0] cmp_special,
	output logic [6:0] code
);

	// Run states outrank execution events, so a monitor never misses them.
	always_comb
	begin
		code = `PSTAT_STALL;
		case (state)
			core_status_pkg::ST_HALTED: code = `PSTAT_HALTED;
			core_status_pkg::ST_STOPPED: code = `PSTAT_STOPPED;
			core_status_pkg::ST_CHKSTOP: code = `PSTAT_CHKSTOP;
			default:
			begin
				if (exception)
					code = `PSTAT_EXCEPT;
				else if (squash)
					code = `PSTAT_SQUASH;
				else if (cmp_valid)
				begin
					case (cmp_class)
						core_status_pkg::CMP_GENERIC:
							code = {`PSTAT_GENERIC_BASE, cmp_size16,
								cmp_vle};
						core_status_pkg::CMP_LSM:
							code = cmp_vle ? `PSTAT_LSM_VAR : `PSTAT_LSM_STD;
						core_status_pkg::CMP_SHORT_RFI:
							code = `PSTAT_SHORT_RFI;
						core_status_pkg::CMP_SPECIAL:
							code = cmp_special;
						default:
							code = cmp_special;
					endcase
				end
			end
		endcase
	end

endmodule

// [core_status_top.sv]
// Core status, machine check, checkstop, halt and stop signalling.
`timescale 1ns/100ps
`include "core_status_regs.svh"
// Summary of operation
// - Drive two-bit branch prefetch status output.
// - Prefetch only on taken-predicted buffer hits.
// - Status 0x idle, 10 not taken, 11 taken.
// - Status updates on core clock edges.
// - Machine check out follows any syndrome bit.
// - Checkstop out once checkstop state entered.
// - Halted output exactly mirrors halted state.
// - Stopped output exactly mirrors stopped state.
// - Size flag: 0 is 32 bit, 1 is 16 bit.
// - Page flag: 0 standard page, 1 variable page.
// - Special completions pass cmp_special through, even a generic code.
// - Status bus shows halted, stopped, checkstop codes.
module core_status_top
#(
	parameter int SYN_WIDTH = `SYNDROME_WIDTH
)
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic halt_req_pin,
	input wire logic stop_req_pin,
	input wire logic core_idle,
	input wire logic btb_lookup,
	input wire logic btb_hit,
	input wire logic btb_pred_taken,
	input wire logic br_resolve,
	input wire logic br_taken,
	input wire logic [SYN_WIDTH-1:0] mc_set,
	input wire logic [SYN_WIDTH-1:0] mc_clear,
	input wire logic checkstop_event,
	input wire logic exec_exception,
	input wire logic exec_squash,
	input wire logic cmp_valid,
	input wire core_status_pkg::cmp_class_t cmp_class,
	input wire logic cmp_size16,
	input wire logic cmp_vle,
	input wire logic [6:0] cmp_special,
	output logic prefetch_q,
	output logic [1:0] brstat_q,
	output logic [SYN_WIDTH-1:0] machine_check_syndrome_reg,
	output logic mcp_out_q,
	output logic chkstop_q,
	output logic halted_q,
	output logic stopped_q,
	output logic [6:0] pstat_q
);

	////////////////////////////////////////////////////////////////////////
	// Reset release and pin synchronisation.

	logic rst_meta_q;
	logic rst_sync_b;
	logic halt_req;
	logic stop_req;

	// Assertion is immediate; release waits two edges to avoid metastability.
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_b <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_sync_b <= rst_meta_q;
		end
	end

	sync2 #(.WIDTH(2)) u_req_sync
	(
		.clock(clock),
		.rst_b(rst_sync_b),
		.async_in({halt_req_pin, stop_req_pin}),
		.sync_out({halt_req, stop_req})
	);

	////////////////////////////////////////////////////////////////////////
	// Branch prefetch status.

	logic prefetch_issue;
	logic pend_q;

	assign prefetch_issue = btb_lookup && btb_hit && btb_pred_taken;

	always_ff @(posedge clock or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			prefetch_q <= 1'b0;
		else
			prefetch_q <= prefetch_issue;
	end

	// A new issue in the resolve cycle belongs to the next branch, so it wins.
	always_ff @(posedge clock or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			pend_q <= 1'b0;
		else if (prefetch_issue)
			pend_q <= 1'b1;
		else if (br_resolve)
			pend_q <= 1'b0;
	end

	always_ff @(posedge clock or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			brstat_q <= `BRSTAT_IDLE;
		else if (br_resolve && pend_q)
			brstat_q <= br_taken ? `BRSTAT_TAKEN : `BRSTAT_NOT_TAKEN;
		else
			brstat_q <= `BRSTAT_IDLE;
	end

	a_brstat_code: assert property (@(posedge clock) disable iff (!rst_sync_b)
		br_resolve && pend_q |=> brstat_q == {1'b1, $past(br_taken)})
		else $error("prefetch status code wrong after resolve");

	a_brstat_idle: assert property (@(posedge clock) disable iff (!rst_sync_b)
		!(br_resolve && pend_q) |=> !brstat_q[`BRSTAT_VALID_BIT])
		else $error("prefetch status reported without a prefetch");

	a_prefetch_taken: assert property (@(posedge clock) disable iff (!rst_sync_b)
		prefetch_q |-> $past(btb_hit) && $past(btb_pred_taken))
		else $error("prefetch issued for a non-taken prediction");

	////////////////////////////////////////////////////////////////////////
	// Machine check syndrome and checkstop.

	logic [SYN_WIDTH-1:0] syndrome_d;
	logic chk_pend_q;

	// A condition arriving with a clear of the same bit keeps the bit set.
	assign syndrome_d = (machine_check_syndrome_reg & ~mc_clear) | mc_set;

	always_ff @(posedge clock or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			machine_check_syndrome_reg <= SYN_WIDTH'(`SYNDROME_RESET);
			mcp_out_q <= 1'b0;
		end
		else
		begin
			machine_check_syndrome_reg <= syndrome_d;
			mcp_out_q <= |syndrome_d;
		end
	end

	a_mcp_tracks: assert property (@(posedge clock) disable iff (!rst_sync_b)
		mcp_out_q == (|machine_check_syndrome_reg))
		else $error("machine check output disagrees with syndrome");

	// The condition is sticky; the state is entered once the core drains.
	always_ff @(posedge clock or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			chk_pend_q <= 1'b0;
		else if (checkstop_event)
			chk_pend_q <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Run state machine.

	core_status_pkg::run_state_t state_q;
	core_status_pkg::run_state_t state_d;

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			core_status_pkg::ST_RUN:
			begin
				if (chk_pend_q && core_idle)
					state_d = core_status_pkg::ST_CHKSTOP;
				else if (stop_req && core_idle)
					state_d = core_status_pkg::ST_STOPPED;
				else if (halt_req && core_idle)
					state_d = core_status_pkg::ST_HALTED;
			end
			core_status_pkg::ST_HALTED:
			begin
				if (chk_pend_q)
					state_d = core_status_pkg::ST_CHKSTOP;
				else if (stop_req)
					state_d = core_status_pkg::ST_STOPPED;
				else if (!halt_req)
					state_d = core_status_pkg::ST_RUN;
			end
			core_status_pkg::ST_STOPPED:
			begin
				if (chk_pend_q)
					state_d = core_status_pkg::ST_CHKSTOP;
				else if (!stop_req)
					state_d = halt_req ? core_status_pkg::ST_HALTED
						: core_status_pkg::ST_RUN;
			end
			core_status_pkg::ST_CHKSTOP:
				state_d = core_status_pkg::ST_CHKSTOP;
			default:
				state_d = core_status_pkg::ST_RUN;
		endcase
	end

	always_ff @(posedge clock or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			state_q <= core_status_pkg::ST_RUN;
		else
			state_q <= state_d;
	end

	// Indications are registered from the next state so they match state_q.
	always_ff @(posedge clock or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			halted_q <= 1'b0;
			stopped_q <= 1'b0;
			chkstop_q <= 1'b0;
		end
		else
		begin
			halted_q <= state_d == core_status_pkg::ST_HALTED;
			stopped_q <= state_d == core_status_pkg::ST_STOPPED;
			chkstop_q <= state_d == core_status_pkg::ST_CHKSTOP;
		end
	end

	a_halted_exact: assert property (@(posedge clock) disable iff (!rst_sync_b)
		halted_q == (state_q == core_status_pkg::ST_HALTED))
		else $error("halted output does not match halted state");

	a_stopped_exact: assert property (@(posedge clock) disable iff (!rst_sync_b)
		stopped_q == (state_q == core_status_pkg::ST_STOPPED))
		else $error("stopped output does not match stopped state");

	a_halt_entry: assert property (
		@(posedge clock) disable iff (!rst_sync_b)
		$rose(halted_q) |-> $past(halt_req))
		else $error("halted entered without a request");

	a_stop_entry: assert property (
		@(posedge clock) disable iff (!rst_sync_b)
		$rose(stopped_q) |-> $past(stop_req))
		else $error("stopped entered without a request");

	a_chkstop_sticky: assert property (@(posedge clock) disable iff (!rst_sync_b)
		chkstop_q |=> chkstop_q && !halted_q && !stopped_q)
		else $error("checkstop output was released");

	a_chkstop_entry: assert property (@(posedge clock) disable iff (!rst_sync_b)
		$rose(chkstop_q) |-> $past(chk_pend_q))
		else $error("checkstop entered without a condition");

	a_halt_leave: assert property (@(posedge clock) disable iff (!rst_sync_b)
		halted_q && !halt_req && !stop_req && !chk_pend_q |=> !halted_q)
		else $error("halted state held after request dropped");

	////////////////////////////////////////////////////////////////////////
	// Processor status bus.

	logic [6:0] pstat_d;

	pstat_encoder u_pstat_encoder
	(
		.state(state_d),
		.exception(exec_exception),
		.squash(exec_squash),
		.cmp_valid(cmp_valid),
		.cmp_class(cmp_class),
		.cmp_size16(cmp_size16),
		.cmp_vle(cmp_vle),
		.cmp_special(cmp_special),
		.code(pstat_d)
	);

	always_ff @(posedge clock or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			pstat_q <= `PSTAT_STALL;
		else
			pstat_q <= pstat_d;
	end

	a_pstat_state: assert property (@(posedge clock) disable iff (!rst_sync_b)
		halted_q |-> pstat_q == `PSTAT_HALTED)
		else $error("status bus does not show halted code");

	a_pstat_generic: assert property (@(posedge clock) disable iff (!rst_sync_b)
		cmp_valid && cmp_class == core_status_pkg::CMP_GENERIC
		&& !exec_exception && !exec_squash
		&& state_d == core_status_pkg::ST_RUN
		|=> pstat_q == {`PSTAT_GENERIC_BASE, $past(cmp_size16),
		$past(cmp_vle)})
		else $error("generic completion flags wrong");

	a_pstat_special: assert property (@(posedge clock) disable iff (!rst_sync_b)
		cmp_valid && cmp_class != core_status_pkg::CMP_GENERIC
		&& !exec_exception && !exec_squash
		&& state_d == core_status_pkg::ST_RUN
		&& cmp_special[6:2] != `PSTAT_GENERIC_BASE
		|=> pstat_q[6:2] != `PSTAT_GENERIC_BASE)
		else $error("special completion used generic code");

endmodule

// [sys_ctrl_model.sv]
// Model of the system controller that asks the core to halt or stop.
`timescale 1ns/100ps
module sys_ctrl_model
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic want_halt,
	input wire logic want_stop,
	input wire logic [3:0] lag,
	input wire logic halted_q,
	input wire logic stopped_q,
	output logic halt_req_pin,
	output logic stop_req_pin
);
////////////////////////////////////////
logic [3:0] lag_q;
logic ready;

assign ready = (lag_q == lag);

// A slow controller waits lag cycles before it raises a request.
always_ff @(posedge clock or negedge rst_b)
begin
	if (!rst_b)
		lag_q <= 4'h0;
	else if (!(want_halt | want_stop))
		lag_q <= 4'h0;
	else if (!ready)
		lag_q <= lag_q + 4'h1;
end

// A request stays up until the core shows it, so a short want is not lost.
always_ff @(posedge clock or negedge rst_b)
begin
	if (!rst_b)
	begin
		halt_req_pin <= 1'h0;
		stop_req_pin <= 1'h0;
	end
	else
	begin
		halt_req_pin <= (want_halt & ready)
			| (halt_req_pin & ~halted_q);
		stop_req_pin <= (want_stop & ready)
			| (stop_req_pin & ~stopped_q);
	end
end
endmodule

// [core_status_top_test.sv]
// Self-checking bench of the core status block.
`timescale 1ns/100ps
module core_status_top_test;
logic clock = 1'h0;
logic rst_b = 1'h0;
logic want_halt = 1'h0, want_stop = 1'h0, core_idle = 1'h1;
logic [3:0] lag = 4'h0;
logic lk = 1'h0, hit = 1'h0, pt = 1'h0, res = 1'h0, tk = 1'h0;
logic [7:0] mset = 8'h00, mclr = 8'h00;
logic cs_ev = 1'h0, ex = 1'h0, sq = 1'h0, cv = 1'h0, s16 = 1'h0, vle = 1'h0;
core_status_pkg::cmp_class_t cls = core_status_pkg::CMP_GENERIC;
logic [6:0] sp = 7'h00;
logic halt_req_pin, stop_req_pin, prefetch_q, mcp_out_q;
logic chkstop_q, halted_q, stopped_q;
logic [1:0] brstat_q;
logic [7:0] syn;
logic [6:0] pstat_q;
wire logic [2:0] st_flags = {chkstop_q, stopped_q, halted_q};
int errors = 0;
int n_tests = 0;

always #25 clock = ~clock;

core_status_top u_core_status_top (.clock(clock), .rst_b(rst_b),
	.halt_req_pin(halt_req_pin), .stop_req_pin(stop_req_pin),
	.core_idle(core_idle), .btb_lookup(lk), .btb_hit(hit),
	.btb_pred_taken(pt), .br_resolve(res), .br_taken(tk), .mc_set(mset),
	.mc_clear(mclr), .checkstop_event(cs_ev), .exec_exception(ex),
	.exec_squash(sq), .cmp_valid(cv), .cmp_class(cls), .cmp_size16(s16),
	.cmp_vle(vle), .cmp_special(sp), .prefetch_q(prefetch_q),
	.brstat_q(brstat_q), .machine_check_syndrome_reg(syn),
	.mcp_out_q(mcp_out_q), .chkstop_q(chkstop_q), .halted_q(halted_q),
	.stopped_q(stopped_q), .pstat_q(pstat_q));

sys_ctrl_model u_sys_ctrl_model (.clock(clock), .rst_b(rst_b),
	.want_halt(want_halt), .want_stop(want_stop), .lag(lag),
	.halted_q(halted_q), .stopped_q(stopped_q),
	.halt_req_pin(halt_req_pin), .stop_req_pin(stop_req_pin));
////////////////////////////////////////
task automatic check(input logic [7:0] got, input logic [7:0] exp);
	n_tests++;
	if (got !== exp)
	begin
		errors++;
		$display("[ERR] %0t got %h exp %h", $time, got, exp);
	end
endtask

task automatic end_sim();
	if (errors == 0 && n_tests > 0)
		$display("RESULT: PASS");
	else
		$display("RESULT: FAIL");
	$finish;
endtask

// Latency of state entry is left open, so only a bounded wait is used.
task automatic wait_flag(input int w, input logic v);
	for (int k = 0; k < 20; k++)
	begin
		@(posedge clock);
		#1;
		if (st_flags[w] === v)
			break;
	end
endtask

function automatic logic [6:0] exp_code(logic [13:0] r, logic [6:0] c);
	if (r[11:10] == 2'h3)
		return 7'h04;
	if (r[13:12] == 2'h3)
		return 7'h08;
	if (!r[5])
		return 7'h00;
	case (r[7:6])
		2'h0: return {5'h10, r[8], r[9]};
		2'h1: return r[9] ? 7'h4b : 7'h44;
		2'h2: return 7'h7c;
		default: return c;
	endcase
endfunction
////////////////////////////////////////
initial
begin
	#200000;
	errors++;
	end_sim();
end

initial
begin
	logic [31:0] r, r2;
	logic pend, e_pf;
	logic [1:0] e_br;
	logic [7:0] e_syn;
	logic [6:0] e_ps;
	pend = 1'h0;
	e_pf = 1'h0;
	e_br = 2'h0;
	e_syn = 8'h00;
	e_ps = 7'h00;
	r = $urandom(96737);
	repeat (8) @(posedge clock);
	rst_b <= 1'h1;
	repeat (6) @(posedge clock);
	// Lookups are held back while one prefetch is pending: one per resolve.
	for (int i = 0; i <= 300; i++)
	begin
		@(posedge clock);
		r = (i == 300) ? 32'h0 : $urandom;
		r2 = (i == 300) ? 32'h0 : $urandom;
		r[0] = r[0] & ~pend;
		lk <= r[0];
		hit <= r[1];
		pt <= r[2];
		res <= r[3];
		tk <= r[4];
		cv <= r[5];
		cls <= core_status_pkg::cmp_class_t'({1'h0, r[7:6]});
		s16 <= r[8];
		vle <= r[9];
		ex <= (r[11:10] == 2'h3);
		sq <= (r[13:12] == 2'h3);
		mset <= r[21:14] & r[29:22];
		mclr <= r2[7:0] & r2[15:8];
		sp <= r2[22:16];
		#1;
		check(8'(prefetch_q), 8'(e_pf));
		check(8'(brstat_q), 8'(e_br));
		check(syn, e_syn);
		check(8'(mcp_out_q), 8'(|e_syn));
		check(8'(pstat_q), 8'(e_ps));
		e_pf = r[0] & r[1] & r[2];
		e_br = (r[3] & pend) ? {1'h1, r[4]} : 2'h0;
		pend = e_pf | (pend & ~r[3]);
		e_syn = (e_syn & ~(r2[7:0] & r2[15:8])) | (r[21:14] & r[29:22]);
		e_ps = exp_code(r[13:0], r2[22:16]);
	end
	@(posedge clock) core_idle <= 1'h0;
	want_halt <= 1'h1;
	repeat (10) @(posedge clock);
	#1 check(8'(st_flags), 8'h00);
	@(posedge clock) core_idle <= 1'h1;
	wait_flag(0, 1'h1);
	check(8'(st_flags), 8'h01);
	check(8'(pstat_q), 8'h20);
	@(posedge clock) want_stop <= 1'h1;
	wait_flag(1, 1'h1);
	check(8'(st_flags), 8'h02);
	check(8'(pstat_q), 8'h24);
	@(posedge clock) want_stop <= 1'h0;
	wait_flag(1, 1'h0);
	check(8'(st_flags), 8'h01);
	@(posedge clock) want_halt <= 1'h0;
	wait_flag(0, 1'h0);
	check(8'(st_flags), 8'h00);
	check(8'(pstat_q), 8'h00);
	@(posedge clock) lag <= 4'h5;
	want_stop <= 1'h1;
	wait_flag(1, 1'h1);
	check(8'(st_flags), 8'h02);
	@(posedge clock) want_stop <= 1'h0;
	wait_flag(1, 1'h0);
	check(8'(st_flags), 8'h00);
	@(posedge clock) core_idle <= 1'h0;
	cs_ev <= 1'h1;
	@(posedge clock) cs_ev <= 1'h0;
	repeat (4) @(posedge clock);
	#1 check(8'(chkstop_q), 8'h00);
	@(posedge clock) core_idle <= 1'h1;
	wait_flag(2, 1'h1);
	check(8'(st_flags), 8'h04);
	check(8'(pstat_q), 8'h28);
	// Checkstop is sticky, so a halt request now must be ignored.
	@(posedge clock) want_halt <= 1'h1;
	repeat (10) @(posedge clock);
	#1 check(8'(st_flags), 8'h04);
	@(posedge clock) rst_b <= 1'h0;
	repeat (8) @(posedge clock);
	#1 check(8'(st_flags), 8'h00);
	check(8'(pstat_q), 8'h00);
	check(syn, 8'h00);
	end_sim();
end
endmodule
